// *** rtl/uim_top.sv ***
// Dual channel UART interrupt masking, line state and AXI4-Lite register slave
//
// Design decisions made here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// How it works
// - CTS rising edge interrupts when mask bit 7
// - RTS rising edge interrupts when mask bit 6
// - Mask bit 5 gates received Xoff interrupt
// - Mask bit 4 enables sleep, gates nothing
// - Mask bit 3 gates any modem change
// - Mask bit 2 gates receive line errors
// - Mask bit 1 gates transmit empty interrupt
// - Non-FIFO: receive interrupt while holding register full
// - FIFO: receive interrupt while fill reaches trigger
// - Ident receive bit follows the mode-dependent receive condition
// - Data-ready bit set while receive FIFO nonempty
// - Tx empty interrupt cleared by ident read or tx_write
// - Mask bits 7..5 and 3..0 all zero means polling
// - Line bits 4..1 show receive errors
// - Bit 6 both empty, bit 5 FIFO empty
// - Bit 7 flags errors within receive FIFO
// - Mask register resets to zero
// - Each channel drives its own interrupt pin
// - Upper mask bits writable only when unlocked
// - FIFO enable bit selects FIFO interrupt behaviour
module uim_top #(
    parameter int NCH = 2
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [NCH-1:0] cts_pin,
    input wire logic [NCH-1:0] rts_state,
    input wire logic [NCH-1:0] xoff_seen,
    input wire logic [NCH*4-1:0] modem_change,
    input wire logic [NCH*4-1:0] rx_error,
    input wire logic [NCH-1:0] rx_fifo_nonempty,
    input wire logic [NCH-1:0] rx_trigger_hit,
    input wire logic [NCH-1:0] rx_fifo_has_error,
    input wire logic [NCH-1:0] tx_fifo_empty,
    input wire logic [NCH-1:0] tx_shifter_empty,
    input wire logic [NCH-1:0] tx_write,
    output logic [NCH-1:0] sleep_mode,
    output logic [NCH-1:0] fifo_enable,
    output logic chan_a_irq_out,
    output logic chan_b_irq_out
);
    logic [7:0] mask_reg [NCH];
    logic [1:0] ctrl_reg [NCH];
    logic [NCH-1:0] cts_meta_reg, cts_sync_reg, cts_prev_reg, rts_prev_reg;
    logic [NCH-1:0] cts_pend_reg, rts_pend_reg, xoff_pend_reg, tx_pend_reg, tx_empty_prev_reg;
    logic [NCH-1:0] irq_reg;
    logic [7:0] line_w [NCH];
    logic [7:0] ident_w [NCH];
    logic [NCH-1:0] ident_rd;
    logic aw_hold_reg, w_hold_reg;
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic w_lane0_reg;
    logic do_write;
    logic do_read;

    // Channel index from a register address, for registers laid out A then B
    function automatic int chan_of(input logic [7:0] addr);
        return int'(addr[2]);
    endfunction

    // Receive request: mode dependent, non-FIFO uses the holding register state
    function automatic logic rx_req(input logic fifo_on, input logic nonempty, input logic trig);
        return fifo_on ? trig : nonempty;
    endfunction

    // CTS comes from a pin, so it passes two flip-flops first
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cts_meta_reg <= '1; // Starts high so a pin idling high gives no false edge
            cts_sync_reg <= '1;
        end else begin
            cts_meta_reg <= cts_pin;
            cts_sync_reg <= cts_meta_reg;
        end
    end

    // Write channel capture; address and data may arrive in either order
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            aw_addr_reg <= '0;
            w_data_reg <= '0;
            w_lane0_reg <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= uim_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_lane0_reg <= s_axi_wstrb[0];
            end
            if (do_write) begin
                aw_hold_reg <= 1'b0;
                w_hold_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr_reg[7:4] == 4'h0) ? uim_pkg::RESP_OKAY : uim_pkg::RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Ready only while the slot is empty and no response waits
    assign s_axi_awready = !aw_hold_reg && !s_axi_bvalid;
    assign s_axi_wready = !w_hold_reg && !s_axi_bvalid;
    assign do_write = aw_hold_reg && w_hold_reg && !s_axi_bvalid;

    // Mask and control registers; the upper mask half is locked unless unlocked
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int c = 0; c < NCH; c++) begin
                mask_reg[c] <= uim_pkg::MASK_RESET;
                ctrl_reg[c] <= uim_pkg::CTRL_RESET;
            end
        end else if (do_write && w_lane0_reg) begin
            for (int c = 0; c < NCH; c++) begin
                if (chan_of(aw_addr_reg) == c && aw_addr_reg[7:3] == uim_pkg::ADDR_MASK_A[7:3]) begin
                    if (ctrl_reg[c][uim_pkg::CB_ENH]) begin
                        mask_reg[c] <= w_data_reg[7:0];
                    end else begin
                        mask_reg[c] <= (mask_reg[c] & uim_pkg::MASK_UPPER) | (w_data_reg[7:0] & ~uim_pkg::MASK_UPPER);
                    end
                end
                if (chan_of(aw_addr_reg) == c && aw_addr_reg[7:3] == uim_pkg::ADDR_CTRL_A[7:3]) begin
                    ctrl_reg[c] <= w_data_reg[1:0];
                end
            end
        end
    end

    // Read channel; reading the ident register is a side effect that clears the CTS, RTS, Xoff and tx sources
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= uim_pkg::RESP_OKAY;
        end else if (do_read) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= uim_pkg::RESP_OKAY;
            case (s_axi_araddr & 8'hFB)
                uim_pkg::ADDR_MASK_A: s_axi_rdata <= {24'h000000, mask_reg[chan_of(s_axi_araddr)]};
                uim_pkg::ADDR_CTRL_A: s_axi_rdata <= {30'h0, ctrl_reg[chan_of(s_axi_araddr)]};
                uim_pkg::ADDR_LINE_A: s_axi_rdata <= {24'h000000, line_w[chan_of(s_axi_araddr)]};
                uim_pkg::ADDR_IDENT_A: s_axi_rdata <= {24'h000000, ident_w[chan_of(s_axi_araddr)]};
                default: begin
                    s_axi_rdata <= '0;
                    s_axi_rresp <= uim_pkg::RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    assign s_axi_arready = !s_axi_rvalid;
    assign do_read = s_axi_arvalid && s_axi_arready;

    // Line state and identification views, combinational from live inputs and the sticky pending registers
    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            line_w[c] = '0;
            line_w[c][uim_pkg::LB_DATA] = rx_fifo_nonempty[c];
            line_w[c][uim_pkg::LB_ERR_HI:uim_pkg::LB_ERR_LO] = rx_error[c*4 +: 4];
            line_w[c][uim_pkg::LB_THR_EMPTY] = tx_fifo_empty[c];
            line_w[c][uim_pkg::LB_TX_IDLE] = tx_fifo_empty[c] && tx_shifter_empty[c];
            line_w[c][uim_pkg::LB_FIFO_ERR] = rx_fifo_has_error[c];
            ident_w[c] = '0;
            ident_w[c][uim_pkg::IB_RX] = mask_reg[c][uim_pkg::MB_RX] &&
                rx_req(ctrl_reg[c][uim_pkg::CB_FIFO_EN], rx_fifo_nonempty[c], rx_trigger_hit[c]);
            ident_w[c][uim_pkg::IB_TX] = mask_reg[c][uim_pkg::MB_TX] && tx_pend_reg[c];
            ident_w[c][uim_pkg::IB_LINE] = mask_reg[c][uim_pkg::MB_LINE] && (|rx_error[c*4 +: 4]);
            ident_w[c][uim_pkg::IB_MODEM] = mask_reg[c][uim_pkg::MB_MODEM] && (|modem_change[c*4 +: 4]);
            ident_w[c][uim_pkg::IB_XOFF] = mask_reg[c][uim_pkg::MB_XOFF] && xoff_pend_reg[c];
            ident_w[c][uim_pkg::IB_CTS] = mask_reg[c][uim_pkg::MB_CTS] && cts_pend_reg[c];
            ident_w[c][uim_pkg::IB_RTS] = mask_reg[c][uim_pkg::MB_RTS] && rts_pend_reg[c];
            ident_w[c][uim_pkg::IB_NONE] = ~(|ident_w[c][7:1]);
            ident_rd[c] = do_read && ((s_axi_araddr & 8'hFB) == uim_pkg::ADDR_IDENT_A) && chan_of(s_axi_araddr) == c;
        end
    end

    // Sticky event sources; a new event in the clearing cycle wins
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cts_prev_reg <= '1; // Starts high: a pin idling high after reset is no edge
            rts_prev_reg <= '1;
            tx_empty_prev_reg <= '0;
            cts_pend_reg <= '0;
            rts_pend_reg <= '0;
            xoff_pend_reg <= '0;
            tx_pend_reg <= '0;
        end else begin
            cts_prev_reg <= cts_sync_reg;
            rts_prev_reg <= rts_state;
            tx_empty_prev_reg <= tx_fifo_empty;
            for (int c = 0; c < NCH; c++) begin
                if (cts_sync_reg[c] && !cts_prev_reg[c]) begin
                    cts_pend_reg[c] <= 1'b1;
                end else if (ident_rd[c]) begin
                    cts_pend_reg[c] <= 1'b0;
                end
                if (rts_state[c] && !rts_prev_reg[c]) begin
                    rts_pend_reg[c] <= 1'b1;
                end else if (ident_rd[c]) begin
                    rts_pend_reg[c] <= 1'b0;
                end
                if (xoff_seen[c]) begin
                    xoff_pend_reg[c] <= 1'b1;
                end else if (ident_rd[c]) begin
                    xoff_pend_reg[c] <= 1'b0;
                end
                if (tx_fifo_empty[c] && !tx_empty_prev_reg[c]) begin
                    tx_pend_reg[c] <= 1'b1;
                end else if (ident_rd[c] || tx_write[c]) begin
                    tx_pend_reg[c] <= 1'b0;
                end
            end
        end
    end

    // Interrupt pins and mode outputs, all registered
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_reg <= '0;
            sleep_mode <= '0;
            fifo_enable <= '0;
        end else begin
            for (int c = 0; c < NCH; c++) begin
                irq_reg[c] <= ~ident_w[c][uim_pkg::IB_NONE];
                sleep_mode[c] <= mask_reg[c][uim_pkg::MB_SLEEP];
                fifo_enable[c] <= ctrl_reg[c][uim_pkg::CB_FIFO_EN];
            end
        end
    end

    assign chan_a_irq_out = irq_reg[0];
    assign chan_b_irq_out = irq_reg[1];

    // Channel A mask clears on every reset release
    AST_MASK_RESET: assert property (@(posedge sys_clk)
        $rose(reset_n) |-> mask_reg[0] == 8'h00)
        else $error("mask not zero after reset");

    // Upper mask half holds while locked
    AST_LOCK: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !ctrl_reg[0][1] |=> mask_reg[0][7:4] == $past(mask_reg[0][7:4]))
        else $error("upper mask changed while locked");

    // Polled operation keeps the pin low
    AST_POLL: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (mask_reg[0][3:0] == 4'h0 && mask_reg[0][7:5] == 3'h0) |=> !chan_a_irq_out)
        else $error("interrupt in polled mode");

    // Same on channel B, so crossed pins would show
    AST_POLL_B: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (mask_reg[1][3:0] == 4'h0 && mask_reg[1][7:5] == 3'h0) |=> !chan_b_irq_out)
        else $error("channel b interrupt in polled mode");

    // Any modem change raises the pin a cycle later
    AST_MODEM: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (mask_reg[0][3] && |modem_change[3:0]) |=> chan_a_irq_out)
        else $error("modem interrupt missing");

    // Receive errors raise the pin while enabled
    AST_LINE: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (mask_reg[0][2] && |rx_error[3:0]) |=> chan_a_irq_out)
        else $error("line interrupt missing");

    // Receive request follows the FIFO mode
    AST_RX: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (mask_reg[0][0] && (ctrl_reg[0][0] ? rx_trigger_hit[0] : rx_fifo_nonempty[0])) |=> chan_a_irq_out)
        else $error("receive interrupt missing");

    // An idle receive source alone lets the pin drop
    AST_RX_CLR: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (mask_reg[0][7:5] == 3'h0 && mask_reg[0][3:1] == 3'h0 &&
        !(ctrl_reg[0][0] ? rx_trigger_hit[0] : rx_fifo_nonempty[0])) |=> !chan_a_irq_out)
        else $error("receive interrupt not cleared");

    // Line state read returns both transmit empty bits
    AST_TX_IDLE: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (do_read && s_axi_araddr == uim_pkg::ADDR_LINE_A) |=>
        s_axi_rdata[6:5] == {$past(tx_fifo_empty[0] && tx_shifter_empty[0]), $past(tx_fifo_empty[0])})
        else $error("tx empty bits wrong");

    // Line state read returns data ready and error bits
    AST_LINE_RD: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (do_read && s_axi_araddr == uim_pkg::ADDR_LINE_A) |=> {s_axi_rdata[7], s_axi_rdata[4:0]} ==
        {$past(rx_fifo_has_error[0]), $past(rx_error[3:0]), $past(rx_fifo_nonempty[0])})
        else $error("line state bits wrong");

    // CTS edge: pending next cycle, pin the cycle after
    AST_CTS: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (cts_sync_reg[1] && !cts_prev_reg[1] && mask_reg[1][7]) |=> ##1 chan_b_irq_out)
        else $error("cts interrupt missing");

    // RTS edge behaves like the CTS edge
    AST_RTS: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (rts_state[1] && !rts_prev_reg[1] && mask_reg[1][6]) |=> ##1 chan_b_irq_out)
        else $error("rts interrupt missing");

    // Received Xoff raises the pin when enabled
    AST_XOFF: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (xoff_seen[1] && mask_reg[1][5]) |=> ##1 chan_b_irq_out)
        else $error("xoff interrupt missing");

    // Transmit FIFO going empty raises the pin
    AST_TXSET: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (tx_fifo_empty[1] && !tx_empty_prev_reg[1] && mask_reg[1][1]) |=> ##1 chan_b_irq_out)
        else $error("tx interrupt missing");

    // A holding register write clears the tx source
    AST_TXCLR: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (tx_write[1] && !(tx_fifo_empty[1] && !tx_empty_prev_reg[1])) |=> !tx_pend_reg[1])
        else $error("tx pending not cleared");

    // Sleep output trails its mask bit by one cycle
    AST_SLEEP: assert property (@(posedge sys_clk) disable iff (!reset_n)
        ##1 sleep_mode[0] == $past(mask_reg[0][4]))
        else $error("sleep output wrong");

    // FIFO enable output trails its control bit
    AST_FIFO_EN: assert property (@(posedge sys_clk) disable iff (!reset_n)
        ##1 fifo_enable[0] == $past(ctrl_reg[0][0]))
        else $error("fifo enable output wrong");
endmodule

// *** include/uim_pkg.sv ***
// Package: register map, field positions and reset values for the UART interrupt mask block
package uim_pkg;
    // Register byte addresses on the AXI4-Lite slave
    localparam logic [7:0] ADDR_MASK_A = 8'h00;
    localparam logic [7:0] ADDR_MASK_B = 8'h04;
    localparam logic [7:0] ADDR_CTRL_A = 8'h08;
    localparam logic [7:0] ADDR_CTRL_B = 8'h0C;
    localparam logic [7:0] ADDR_LINE_A = 8'h10;
    localparam logic [7:0] ADDR_LINE_B = 8'h14;
    localparam logic [7:0] ADDR_IDENT_A = 8'h18;
    localparam logic [7:0] ADDR_IDENT_B = 8'h1C;
    // Interrupt mask fields
    localparam int MB_CTS = 7;
    localparam int MB_RTS = 6;
    localparam int MB_XOFF = 5;
    localparam int MB_SLEEP = 4;
    localparam int MB_MODEM = 3;
    localparam int MB_LINE = 2;
    localparam int MB_TX = 1;
    localparam int MB_RX = 0;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] MASK_UPPER = 8'hF0;
    // Control register: bit 0 fifo enable, bit 1 enhanced-feature unlock
    localparam int CB_FIFO_EN = 0;
    localparam int CB_ENH = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    // Line state fields
    localparam int LB_DATA = 0;
    localparam int LB_ERR_LO = 1;
    localparam int LB_ERR_HI = 4;
    localparam int LB_THR_EMPTY = 5;
    localparam int LB_TX_IDLE = 6;
    localparam int LB_FIFO_ERR = 7;
    // Identification register: pending source bits, bit 0 set when none pending
    localparam int IB_NONE = 0;
    localparam int IB_RX = 1;
    localparam int IB_TX = 2;
    localparam int IB_LINE = 3;
    localparam int IB_MODEM = 4;
    localparam int IB_XOFF = 5;
    localparam int IB_CTS = 6;
    localparam int IB_RTS = 7;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** tb/uim_irq_host.sv ***
// Far-side host model: watches each channel interrupt pin and counts assertions
`timescale 1ns/1ps
module uim_irq_host (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic irq_a,
    input wire logic irq_b,
    output logic [7:0] edges_a,
    output logic [7:0] edges_b
);
    logic irq_a_reg;
    logic irq_b_reg;
    // Count each pin separately, so a crossed channel shows up as a count on the wrong pin
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_a_reg <= 1'b0;
            irq_b_reg <= 1'b0;
            edges_a <= 8'h00;
            edges_b <= 8'h00;
        end else begin
            irq_a_reg <= irq_a;
            irq_b_reg <= irq_b;
            if (irq_a && !irq_a_reg) edges_a <= edges_a + 8'h01;
            if (irq_b && !irq_b_reg) edges_b <= edges_b + 8'h01;
        end
    end
endmodule

// *** tb/tb_top.sv ***
// Testbench: register access, random level sources, edge sources on channel B
`timescale 1ns/1ps
module tb_top;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, modem_change = 8'h00, rx_error = 8'h00;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, chan_a_irq_out, chan_b_irq_out;
    logic [1:0] s_axi_bresp, s_axi_rresp, sleep_mode, fifo_enable;
    logic [31:0] s_axi_rdata;
    logic [1:0] cts_pin = 2'h0, rts_state = 2'h0, xoff_seen = 2'h0, rx_fifo_nonempty = 2'h0, rx_trigger_hit = 2'h0;
    logic [1:0] rx_fifo_has_error = 2'h0, tx_fifo_empty = 2'h0, tx_shifter_empty = 2'h0, tx_write = 2'h0;
    logic [7:0] irq_edges_a, irq_edges_b;
    logic [31:0] seed = 32'h1D;
    int errors = 0;
    int n_tests = 0;
    int mb[4] = '{uim_pkg::MB_CTS, uim_pkg::MB_RTS, uim_pkg::MB_XOFF, uim_pkg::MB_TX};
    int ib[4] = '{uim_pkg::IB_CTS, uim_pkg::IB_RTS, uim_pkg::IB_XOFF, uim_pkg::IB_TX};

    // Clock at 50 MHz
    always #10 sys_clk = ~sys_clk;

    uim_top u_dut (.sys_clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cts_pin, .rts_state, .xoff_seen,
        .modem_change, .rx_error, .rx_fifo_nonempty, .rx_trigger_hit, .rx_fifo_has_error, .tx_fifo_empty,
        .tx_shifter_empty, .tx_write, .sleep_mode, .fifo_enable, .chan_a_irq_out, .chan_b_irq_out);
    uim_irq_host u_host (.sys_clk, .reset_n, .irq_a(chan_a_irq_out), .irq_b(chan_b_irq_out),
        .edges_a(irq_edges_a), .edges_b(irq_edges_b));

    // Random source and bench helpers
    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction
    function automatic logic [7:0] exp_ident(input logic [7:0] m, input logic f, md, ln, ne, tr);
        logic [7:0] e;
        e = 8'h00;
        e[uim_pkg::IB_RX] = m[uim_pkg::MB_RX] & (f ? tr : ne);
        e[uim_pkg::IB_LINE] = m[uim_pkg::MB_LINE] & ln;
        e[uim_pkg::IB_MODEM] = m[uim_pkg::MB_MODEM] & md;
        e[uim_pkg::IB_NONE] = (e == 8'h00);
        return e;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic summarize;
        $display("comparisons=%0d mismatches=%0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic clk(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // Write holds each channel until its own ready; bready stays up until the response
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge sys_clk);
            if (s_axi_awready && !aw_ok) begin aw_ok = 1'b1; s_axi_awvalid <= 1'b0; end
            if (s_axi_wready && !w_ok) begin w_ok = 1'b1; s_axi_wvalid <= 1'b0; end
        end
        while (!s_axi_bvalid) @(posedge sys_clk);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge sys_clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        while (!s_axi_rvalid) @(posedge sys_clk);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // Channel B edge sources: 0 cts, 1 rts, 2 xoff, 3 tx empty
    task automatic set_src(input int k, input logic v);
        @(posedge sys_clk);
        case (k)
            0: cts_pin[1] <= v;
            1: rts_state[1] <= v;
            2: xoff_seen[1] <= v;
            default: tx_fifo_empty[1] <= v;
        endcase
    endtask

    // Main sequence
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        logic [7:0] m, e;
        logic f;
        clk(2);
        reset_n <= 1'b1;
        axi_rd(uim_pkg::ADDR_MASK_A, d, r); chk(d, 32'h0);
        axi_rd(uim_pkg::ADDR_MASK_B, d, r); chk(d, 32'h0);
        chk({sleep_mode, chan_b_irq_out, chan_a_irq_out}, 32'h0);
        $display("test reset done");
        axi_wr(uim_pkg::ADDR_MASK_A, 32'hFF, r); axi_rd(uim_pkg::ADDR_MASK_A, d, r); chk(d, 32'h0F);
        axi_wr(uim_pkg::ADDR_CTRL_A, 32'h2, r); axi_wr(uim_pkg::ADDR_MASK_A, 32'hFF, r);
        axi_rd(uim_pkg::ADDR_MASK_A, d, r); chk(d, 32'hFF);
        chk(sleep_mode[0], 32'h1);
        axi_wr(uim_pkg::ADDR_CTRL_A, 32'h0, r); axi_wr(uim_pkg::ADDR_MASK_A, 32'h0, r);
        axi_rd(uim_pkg::ADDR_MASK_A, d, r); chk(d, 32'hF0);
        axi_wr(8'h40, 32'h1, r); chk(r, uim_pkg::RESP_SLVERR);
        axi_rd(8'h20, d, r); chk(r, uim_pkg::RESP_SLVERR); chk(d, 32'h0);
        $display("test registers done");
        for (int i = 0; i < 40; i++) begin
            seed = xs(seed);
            m = seed[7:0] & 8'h1D;
            f = seed[8];
            if (i < 2) begin m = (i == 0) ? 8'h00 : 8'h1D; f = (i == 0); end
            axi_wr(uim_pkg::ADDR_CTRL_A, {30'h0, 1'b1, f}, r);
            axi_wr(uim_pkg::ADDR_MASK_A, {24'h0, m}, r);
            seed = xs(seed);
            if (i < 2) seed[12:0] = 13'h1FFF;
            @(posedge sys_clk);
            modem_change[3:0] <= seed[3:0];
            rx_error[3:0] <= seed[7:4];
            rx_fifo_nonempty[0] <= seed[8];
            rx_trigger_hit[0] <= seed[9];
            rx_fifo_has_error[0] <= seed[10];
            tx_fifo_empty[0] <= seed[11];
            tx_shifter_empty[0] <= seed[12];
            clk(3);
            e = exp_ident(m, f, |seed[3:0], |seed[7:4], seed[8], seed[9]);
            chk(chan_a_irq_out, !e[uim_pkg::IB_NONE]);
            chk({chan_b_irq_out, sleep_mode[0], fifo_enable[0]}, {1'b0, m[4], f});
            axi_rd(uim_pkg::ADDR_IDENT_A, d, r); chk(d, {24'h0, e});
            axi_rd(uim_pkg::ADDR_LINE_A, d, r);
            chk(d, {24'h0, seed[10], seed[11] & seed[12], seed[11], seed[7:4], seed[8]});
        end
        $display("test random done");
        axi_wr(uim_pkg::ADDR_CTRL_B, 32'h3, r); axi_wr(uim_pkg::ADDR_MASK_B, 32'h10, r);
        clk(2); chk({sleep_mode[1], fifo_enable[1]}, 32'h3);
        for (int k = 0; k < 4; k++) begin
            axi_wr(uim_pkg::ADDR_MASK_B, 32'h1 << mb[k], r);
            axi_rd(uim_pkg::ADDR_IDENT_B, d, r);
            set_src(k, 1'b1); clk(6); chk(chan_b_irq_out, 32'h1);
            set_src(k, 1'b0); axi_rd(uim_pkg::ADDR_IDENT_B, d, r); chk(d, 32'h1 << ib[k]);
            clk(2); chk(chan_b_irq_out, 32'h0);
            if (k == 3) begin
                set_src(3, 1'b1); clk(4); chk(chan_b_irq_out, 32'h1);
                @(posedge sys_clk) tx_write[1] <= 1'b1;
                @(posedge sys_clk) tx_write[1] <= 1'b0;
                clk(3); chk(chan_b_irq_out, 32'h0);
                set_src(3, 1'b0);
            end
            axi_wr(uim_pkg::ADDR_MASK_B, 32'h0, r);
            set_src(k, 1'b1); clk(6); chk(chan_b_irq_out, 32'h0);
            set_src(k, 1'b0);
        end
        chk(irq_edges_b != 8'h00, 32'h1);
        $display("test edges done");
        // Second reset in mid-run, with channel A left holding a random mask
        @(posedge sys_clk) reset_n <= 1'b0;
        clk(2);
        reset_n <= 1'b1;
        axi_rd(uim_pkg::ADDR_MASK_A, d, r); chk(d, 32'h0);
        chk({sleep_mode, fifo_enable, chan_a_irq_out, chan_b_irq_out}, 32'h0);
        $display("test midrun reset done");
        summarize();
    end

    // Watchdog at 20000 cycles, well past the expected run of about a thousand cycles
    initial begin
        #400000;
        errors++;
        summarize();
    end
endmodule
